// ==== core/smbcr_pkg.sv ====
// Constants shared by both ends of the SMBus config-read link
package smbcr_pkg;
  localparam logic [6:0] SLV_ADDR = 7'h68;
  localparam logic [7:0] CMD_SETUP = 8'hBA;
  localparam logic [7:0] CMD_BREAD = 8'hBD;
  localparam logic [7:0] SETUP_CNT = 8'h04;
  localparam logic [7:0] RET_CNT = 8'h04;
  localparam logic [2:0] OP_REG_RD = 3'h4;
  localparam logic [4:0] PORT_LAST = 5'h05;
  localparam logic [7:0] PEC_POLY = 8'h07;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  // Command byte field positions
  localparam int CB3_PSEL0 = 7;
  localparam int CB3_BE_LSB = 2;
  // Device receive byte positions
  localparam logic [2:0] POS_ADDR = 3'h0;
  localparam logic [2:0] POS_CMD = 3'h1;
  localparam logic [2:0] POS_CNT = 3'h2;
  localparam logic [2:0] POS_CB1 = 3'h3;
  localparam logic [2:0] POS_CB2 = 3'h4;
  localparam logic [2:0] POS_CB3 = 3'h5;
  localparam logic [2:0] POS_CB4 = 3'h6;
  localparam logic [2:0] POS_LAST = 3'h7;
  localparam logic [2:0] TX_LAST = 3'h7;
  // Host register map
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_SETUP = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_RINFO = 8'h10;
  localparam logic [7:0] REG_ADDR = 8'h14;
  localparam logic [1:0] OP_SETUP = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam int CMD_PEC_BIT = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NACK = 1;
  localparam int STAT_DONE = 2;
  // Host byte indices within a transaction
  localparam logic [3:0] IDX_SETUP_LAST = 4'h6;
  localparam logic [3:0] IDX_RD_CMD = 4'h1;
  localparam logic [3:0] IDX_RD_ADDR = 4'h2;
  localparam logic [3:0] IDX_RD_CNT = 4'h3;
  localparam logic [3:0] IDX_RD_LAST = 4'h7;
  localparam logic [3:0] IDX_RD_PEC = 4'h8;
  // Timing
  localparam int CLK_SYS_NS = 4;
  localparam int SCL_HALF_NS = 5000;
  localparam int SCL_Q_CYC = (SCL_HALF_NS / 2 + CLK_SYS_NS - 1) / CLK_SYS_NS;
endpackage : smbcr_pkg

// ==== core/smbcr_if.sv ====
// Open-drain SMBus wires joining host and device ends
`timescale 1ns/100ps
interface smbcr_if;
  logic h_scl_o;
  logic h_scl_oe_n;
  logic h_sda_o;
  logic h_sda_oe_n;
  logic d_sda_o;
  logic d_sda_oe_n;
  logic scl;
  logic sda;
  // Wired-AND with pull-ups
  assign scl = h_scl_oe_n | h_scl_o;
  assign sda = (h_sda_oe_n | h_sda_o) & (d_sda_oe_n | d_sda_o);
  modport host (output h_scl_o, output h_scl_oe_n, output h_sda_o, output h_sda_oe_n, input sda);
  modport dev (input scl, input sda, output d_sda_o, output d_sda_oe_n);
endinterface : smbcr_if

// ==== core/smbcr_dev.sv ====
// Device end: SMBus slave for config read setup and block read
// Function
// RL1: Setup block write uses command BAh
// RL2: Setup byte count must be 04h
// RL3: Command byte1 low bits: 011b write, 100b read
// RL4: Port select from byte2[3:0], byte3[7]
// RL5: Port select chooses port 0 to 5
// RL6: Byte3 bits 5:2 are byte enables
// RL7: Enable 0 keeps byte, 1 may modify
// RL8: Address from byte3[1:0], byte4, low zero
// RL9: BDh, repeated start, read: count then data
// RL10: Data returned most significant byte first
// RL11: Master ends setup with STOP, new START
// RL12: Receiver drives ack 0, refuse 1
// RL13: Respond to slave address 1101000b
// RL14: NACK wrong sequence from first bad byte
// RL15: Extra byte after fourth data is PEC
// RL16: Master NACK ends read, stop driving
// RL17: Keep latest setup for later reads
`timescale 1ns/100ps
module smbcr_dev (
  input wire logic clk_sys, // Core clock
  input wire logic clk_link, // Link sampling clock
  input wire logic rst, // Sync reset, clk_sys
  output logic cfg_rd, // Config read pulse
  output logic [4:0] cfg_port, // Port to read
  output logic [11:0] cfg_addr, // Byte address
  output logic [3:0] cfg_be, // Byte enables
  input wire logic [31:0] cfg_rdata, // Data, cycle after cfg_rd
  smbcr_if.dev bus // SMBus pins
);
  import smbcr_pkg::*;

  typedef enum logic [2:0] {D_IDLE, D_RX, D_RACK, D_TX, D_TACK, D_WAIT} smbcr_dst_e;
  typedef enum logic [1:0] {K_NONE, K_SETUP, K_RCMD} smbcr_knd_e;

  typedef struct packed {
    logic rst_m;
    logic rst_s;
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    smbcr_dst_e st;
    smbcr_knd_e kind;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic [2:0] pos;
    logic [2:0] txi;
    logic ackok;
    logic txgo;
    logic rdok;
    logic [7:0] crc;
    logic [3:0] stg_phi;
    logic [4:0] stg_port;
    logic [3:0] stg_be;
    logic [1:0] stg_ahi;
    logic [4:0] port;
    logic [3:0] be;
    logic [9:0] addr;
    logic req_t;
    logic ack_m;
    logic ack_s;
    logic ack_p;
    logic [31:0] data;
    logic oe_n;
  } smbcr_lnk_s;

  typedef struct packed {
    logic req_m;
    logic req_s;
    logic req_p;
    logic rd;
    logic cap;
    logic ack_t;
    logic [31:0] data;
    logic [4:0] port;
    logic [11:0] addr;
    logic [3:0] be;
  } smbcr_sys_s;

  smbcr_lnk_s l_r;
  smbcr_lnk_s l_nxt;
  smbcr_sys_s s_r;
  smbcr_sys_s s_nxt;

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] x;
    x = c ^ b;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ((x << 1) ^ PEC_POLY) : (x << 1);
    end
    return x;
  endfunction : crc8

  function automatic logic [7:0] txbyte(input logic [2:0] i, input logic [31:0] d, input logic [7:0] c);
    case (i)
      3'h0: txbyte = RET_CNT; // [RL9]
      3'h1: txbyte = d[31:24]; // [RL10]
      3'h2: txbyte = d[23:16];
      3'h3: txbyte = d[15:8];
      3'h4: txbyte = d[7:0];
      3'h5: txbyte = c; // [RL15]
      default: txbyte = IDLE_BYTE;
    endcase
  endfunction : txbyte

  ////////////////////////////////////////////////////////////////////////////
  // Link domain
  always_comb begin
    logic strt;
    logic stp;
    logic rise;
    logic fall;
    logic ks;
    logic [7:0] b;
    logic [7:0] tb;
    logic [4:0] psel;
    l_nxt = l_r;
    l_nxt.rst_m = rst;
    l_nxt.rst_s = l_r.rst_m;
    l_nxt.scl_m = bus.scl;
    l_nxt.scl_s = l_r.scl_m;
    l_nxt.scl_p = l_r.scl_s;
    l_nxt.sda_m = bus.sda;
    l_nxt.sda_s = l_r.sda_m;
    l_nxt.sda_p = l_r.sda_s;
    l_nxt.ack_m = s_r.ack_t;
    l_nxt.ack_s = l_r.ack_m;
    l_nxt.ack_p = l_r.ack_s;
    if (l_r.ack_s != l_r.ack_p) begin
      l_nxt.data = s_r.data;
    end
    strt = l_r.scl_s & l_r.scl_p & l_r.sda_p & ~l_r.sda_s;
    stp = l_r.scl_s & l_r.scl_p & ~l_r.sda_p & l_r.sda_s;
    rise = l_r.scl_s & ~l_r.scl_p;
    fall = ~l_r.scl_s & l_r.scl_p;
    ks = (l_r.kind == K_SETUP);
    b = {l_r.sh[6:0], l_r.sda_s};
    psel = {l_r.stg_phi, b[CB3_PSEL0]}; // [RL4]
    // Index stops at its last value, so never wrap back to the count byte
    tb = (l_r.txi == TX_LAST) ? IDLE_BYTE : txbyte(l_r.txi + 3'h1, l_r.data, l_r.crc); // [RL15]
    if (stp) begin
      l_nxt.st = D_IDLE;
      l_nxt.oe_n = 1'b1;
      l_nxt.rdok = 1'b0;
    end else if (strt) begin
      l_nxt.st = D_RX;
      l_nxt.bitc = 4'h0;
      l_nxt.pos = POS_ADDR;
      l_nxt.oe_n = 1'b1;
      l_nxt.kind = K_NONE;
      if (!l_r.rdok) begin
        l_nxt.crc = 8'h00;
      end
    end else begin
      case (l_r.st)
        D_RX: begin
          if (rise) begin
            l_nxt.sh = b;
            l_nxt.bitc = l_r.bitc + 4'h1;
            if (l_r.bitc == 4'h7) begin
              l_nxt.crc = crc8(l_r.crc, b);
              l_nxt.ackok = 1'b0;
              l_nxt.txgo = 1'b0;
              if (l_r.pos != POS_LAST) begin
                l_nxt.pos = l_r.pos + 3'h1;
              end
              case (l_r.pos)
                POS_ADDR: begin
                  if (b[7:1] == SLV_ADDR) begin // [RL13]
                    l_nxt.ackok = ~b[0] | l_r.rdok; // [RL9]
                    l_nxt.txgo = b[0];
                  end
                end
                POS_CMD: begin
                  if (b == CMD_SETUP) begin // [RL1]
                    l_nxt.kind = K_SETUP;
                    l_nxt.ackok = 1'b1;
                  end else if (b == CMD_BREAD) begin // [RL9]
                    l_nxt.kind = K_RCMD;
                    l_nxt.ackok = 1'b1;
                    l_nxt.rdok = 1'b1;
                    l_nxt.req_t = ~l_r.req_t;
                  end
                end
                POS_CNT: l_nxt.ackok = ks && (b == SETUP_CNT); // [RL2]
                POS_CB1: l_nxt.ackok = ks && (b[2:0] == OP_REG_RD); // [RL3]
                POS_CB2: begin
                  l_nxt.ackok = ks;
                  l_nxt.stg_phi = b[3:0]; // [RL4]
                end
                POS_CB3: begin
                  l_nxt.ackok = ks && (psel <= PORT_LAST); // [RL5]
                  l_nxt.stg_port = psel;
                  l_nxt.stg_be = b[CB3_BE_LSB +: 4]; // [RL6]
                  l_nxt.stg_ahi = b[1:0]; // [RL8]
                end
                POS_CB4: begin
                  l_nxt.ackok = ks;
                  if (ks) begin
                    l_nxt.port = l_r.stg_port; // [RL17]
                    l_nxt.be = l_r.stg_be;
                    l_nxt.addr = {l_r.stg_ahi, b}; // [RL8]
                  end
                end
                default: l_nxt.ackok = 1'b0; // [RL14]
              endcase
            end
          end else if (fall && l_r.bitc == 4'h8) begin
            if (l_r.ackok) begin
              l_nxt.oe_n = 1'b0; // [RL12]
              l_nxt.st = D_RACK;
            end else begin
              l_nxt.st = D_WAIT; // [RL14]
            end
          end
        end
        D_RACK: begin
          if (fall) begin
            l_nxt.bitc = 4'h0;
            if (l_r.txgo) begin
              l_nxt.sh = RET_CNT; // [RL9]
              l_nxt.crc = crc8(l_r.crc, RET_CNT);
              l_nxt.txi = 3'h0;
              l_nxt.oe_n = RET_CNT[7];
              l_nxt.st = D_TX;
            end else begin
              l_nxt.oe_n = 1'b1;
              l_nxt.st = D_RX;
            end
          end
        end
        D_TX: begin
          if (rise) begin
            l_nxt.bitc = l_r.bitc + 4'h1;
          end else if (fall) begin
            if (l_r.bitc == 4'h8) begin
              l_nxt.oe_n = 1'b1;
              l_nxt.st = D_TACK;
            end else begin
              l_nxt.sh = {l_r.sh[6:0], 1'b1};
              l_nxt.oe_n = l_r.sh[6];
            end
          end
        end
        D_TACK: begin
          if (rise) begin
            if (l_r.sda_s) begin
              l_nxt.st = D_WAIT; // [RL16]
            end else begin
              l_nxt.sh = tb; // [RL10]
              if (l_r.txi != TX_LAST) begin
                l_nxt.txi = l_r.txi + 3'h1;
              end
              if (l_r.txi < 3'h4) begin
                l_nxt.crc = crc8(l_r.crc, tb);
              end
            end
          end else if (fall) begin
            l_nxt.st = D_TX;
            l_nxt.bitc = 4'h0;
            l_nxt.oe_n = l_r.sh[7];
          end
        end
        D_IDLE, D_WAIT: l_nxt.st = l_r.st;
        default: l_nxt.st = D_IDLE;
      endcase
    end
    if (l_r.rst_s) begin
      l_nxt = '0;
      l_nxt.rst_m = rst;
      l_nxt.rst_s = l_r.rst_m;
      l_nxt.oe_n = 1'b1;
    end
  end

  always_ff @(posedge clk_link) begin
    l_r <= l_nxt;
  end

  assign bus.d_sda_o = 1'b0;
  assign bus.d_sda_oe_n = l_r.oe_n;

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: fetch on request toggle, answer with data and toggle
  always_comb begin
    s_nxt = s_r;
    s_nxt.req_m = l_r.req_t;
    s_nxt.req_s = s_r.req_m;
    s_nxt.req_p = s_r.req_s;
    s_nxt.rd = 1'b0;
    s_nxt.cap = s_r.rd;
    if (s_r.req_s != s_r.req_p) begin
      s_nxt.rd = 1'b1;
      s_nxt.port = l_r.port; // [RL5]
      s_nxt.addr = {l_r.addr, 2'b00}; // [RL8]
      s_nxt.be = l_r.be; // [RL7]
    end
    if (s_r.cap) begin
      s_nxt.data = cfg_rdata;
      s_nxt.ack_t = ~s_r.ack_t;
    end
    if (rst) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    s_r <= s_nxt;
  end

  assign cfg_rd = s_r.rd;
  assign cfg_port = s_r.port;
  assign cfg_addr = s_r.addr;
  assign cfg_be = s_r.be;
endmodule : smbcr_dev

// ==== core/smbcr_host.sv ====
// Host end: SMBus master issuing read setup and block read
`timescale 1ns/100ps
module smbcr_host #(
  parameter int QCYC = smbcr_pkg::SCL_Q_CYC // Cycles per SCL quarter
) (
  input wire logic clk_sys, // Core clock
  input wire logic rst, // Sync reset
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, next cycle
  smbcr_if.host bus // SMBus pins
);
  import smbcr_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_START, H_WBIT, H_RBIT, H_STOP} smbcr_hst_e;

  typedef struct packed {
    smbcr_hst_e st;
    logic [11:0] cnt;
    logic [1:0] ph;
    logic [3:0] bitc;
    logic [3:0] idx;
    logic [7:0] sh;
    logic ackv;
    logic [1:0] op;
    logic pec;
    logic [31:0] setup;
    logic [6:0] addr;
    logic busy;
    logic nack;
    logic done;
    logic [31:0] rdata;
    logic [7:0] rcnt;
    logic [7:0] rpec;
    logic [31:0] dout;
    logic sda_m;
    logic sda_s;
    logic scl;
    logic sda;
  } smbcr_hst_s;

  smbcr_hst_s h_r;
  smbcr_hst_s h_nxt;

  function automatic logic [7:0] wbyte(input logic [1:0] op, input logic [3:0] i, input smbcr_hst_s r);
    wbyte = IDLE_BYTE;
    if (i == 4'h0) begin
      wbyte = {r.addr, 1'b0};
    end else if (op == OP_READ) begin
      wbyte = (i == IDX_RD_CMD) ? CMD_BREAD : {r.addr, 1'b1}; // [RL9]
    end else if (i == 4'h1) begin
      wbyte = CMD_SETUP; // [RL1]
    end else if (i == 4'h2) begin
      wbyte = SETUP_CNT; // [RL2]
    end else if (i <= IDX_SETUP_LAST) begin
      wbyte = r.setup[(6 - i) * 8 +: 8]; // [RL3]
    end
  endfunction : wbyte

  // SCL and SDA levels per phase
  function automatic logic [1:0] pins(input smbcr_hst_e st, input logic [1:0] ph, input logic b);
    case (st)
      H_START: pins = {ph[0] ^ ph[1], ~ph[1]};
      H_STOP: pins = {ph != 2'h0, ph[1]};
      H_WBIT, H_RBIT: pins = {ph[0] ^ ph[1], b};
      default: pins = 2'b11;
    endcase
  endfunction : pins

  always_comb begin
    logic tick;
    logic [3:0] lst;
    logic b;
    h_nxt = h_r;
    h_nxt.sda_m = bus.sda;
    h_nxt.sda_s = h_r.sda_m;
    h_nxt.dout = 32'h0000_0000;
    tick = (h_r.cnt == 12'(QCYC - 1));
    lst = h_r.pec ? IDX_RD_PEC : IDX_RD_LAST; // [RL15]
    if (h_r.st != H_IDLE) begin
      h_nxt.cnt = tick ? 12'h000 : h_r.cnt + 12'h001;
    end
    if (h_r.st != H_IDLE && tick) begin
      h_nxt.ph = h_r.ph + 2'h1;
      if (h_r.ph == 2'h2) begin
        if (h_r.st == H_WBIT && h_r.bitc == 4'h8) begin
          h_nxt.ackv = h_r.sda_s; // [RL12]
        end
        if (h_r.st == H_RBIT && h_r.bitc != 4'h8) begin
          h_nxt.sh = {h_r.sh[6:0], h_r.sda_s};
        end
      end
      if (h_r.ph == 2'h3) begin
        case (h_r.st)
          H_START: begin
            h_nxt.st = H_WBIT;
            h_nxt.bitc = 4'h0;
            h_nxt.sh = wbyte(h_r.op, h_r.idx, h_r);
          end
          H_STOP: begin
            h_nxt.st = H_IDLE;
            h_nxt.busy = 1'b0;
            h_nxt.done = 1'b1;
          end
          H_WBIT: begin
            if (h_r.bitc != 4'h8) begin
              h_nxt.bitc = h_r.bitc + 4'h1;
              h_nxt.sh = {h_r.sh[6:0], 1'b1};
            end else if (h_r.ackv) begin
              h_nxt.nack = 1'b1;
              h_nxt.st = H_STOP;
            end else if (h_r.op == OP_SETUP && h_r.idx == IDX_SETUP_LAST) begin
              h_nxt.st = H_STOP; // [RL11]
            end else if (h_r.op == OP_READ && h_r.idx == IDX_RD_CMD) begin
              h_nxt.st = H_START; // [RL9]
              h_nxt.idx = IDX_RD_ADDR;
            end else if (h_r.op == OP_READ && h_r.idx == IDX_RD_ADDR) begin
              h_nxt.st = H_RBIT;
              h_nxt.bitc = 4'h0;
              h_nxt.idx = IDX_RD_CNT;
            end else begin
              h_nxt.idx = h_r.idx + 4'h1;
              h_nxt.bitc = 4'h0;
              h_nxt.sh = wbyte(h_r.op, h_r.idx + 4'h1, h_r);
            end
          end
          H_RBIT: begin
            if (h_r.bitc != 4'h8) begin
              h_nxt.bitc = h_r.bitc + 4'h1;
            end else begin
              if (h_r.idx == IDX_RD_CNT) begin
                h_nxt.rcnt = h_r.sh;
              end else if (h_r.idx == IDX_RD_PEC) begin
                h_nxt.rpec = h_r.sh;
              end else begin
                h_nxt.rdata = {h_r.rdata[23:0], h_r.sh}; // [RL10]
              end
              h_nxt.bitc = 4'h0;
              h_nxt.idx = h_r.idx + 4'h1;
              if (h_r.idx == lst) begin
                h_nxt.st = H_STOP; // [RL16]
              end
            end
          end
          default: h_nxt.st = H_IDLE;
        endcase
      end
    end
    if (reg_wr && !h_r.busy) begin
      case (reg_addr)
        REG_CMD: begin
          if (reg_wdata[1:0] == OP_SETUP || reg_wdata[1:0] == OP_READ) begin
            h_nxt.op = reg_wdata[1:0];
            h_nxt.pec = reg_wdata[CMD_PEC_BIT];
            h_nxt.busy = 1'b1;
            h_nxt.nack = 1'b0;
            h_nxt.done = 1'b0;
            h_nxt.st = H_START;
            h_nxt.ph = 2'h1;
            h_nxt.cnt = 12'h000;
            h_nxt.idx = 4'h0;
          end
        end
        REG_SETUP: h_nxt.setup = reg_wdata;
        REG_ADDR: h_nxt.addr = reg_wdata[6:0];
        default: h_nxt.op = h_r.op;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_CMD: h_nxt.dout[CMD_PEC_BIT:0] = {h_r.pec, h_r.op};
        REG_SETUP: h_nxt.dout = h_r.setup;
        REG_STAT: begin
          h_nxt.dout[STAT_BUSY] = h_r.busy;
          h_nxt.dout[STAT_NACK] = h_r.nack;
          h_nxt.dout[STAT_DONE] = h_r.done;
        end
        REG_RDATA: h_nxt.dout = h_r.rdata;
        REG_RINFO: h_nxt.dout[15:0] = {h_r.rpec, h_r.rcnt};
        REG_ADDR: h_nxt.dout[6:0] = h_r.addr;
        default: h_nxt.dout = 32'h0000_0000;
      endcase
    end
    // Ack slot of a read byte: ack unless last
    b = h_nxt.sh[7];
    if (h_nxt.st == H_WBIT && h_nxt.bitc == 4'h8) begin
      b = 1'b1;
    end
    if (h_nxt.st == H_RBIT) begin
      b = (h_nxt.bitc != 4'h8) || (h_nxt.idx == lst); // [RL12] [RL16]
    end
    {h_nxt.scl, h_nxt.sda} = pins(h_nxt.st, h_nxt.ph, b);
    if (rst) begin
      h_nxt = '0;
      h_nxt.addr = SLV_ADDR;
      h_nxt.scl = 1'b1;
      h_nxt.sda = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    h_r <= h_nxt;
  end

  assign reg_rdata = h_r.dout;
  assign bus.h_scl_o = 1'b0;
  assign bus.h_scl_oe_n = h_r.scl;
  assign bus.h_sda_o = 1'b0;
  assign bus.h_sda_oe_n = h_r.sda;
endmodule : smbcr_host

// ==== bench/smbcr_monitor.sv ====
// Concurrent checks on the SMBus wires and the device core side
`timescale 1ns/100ps
module smbcr_monitor
  import smbcr_pkg::*;
(
  input wire logic clk_sys, // Core clock
  input wire logic rst, // Sync reset
  input wire logic scl, // Resolved clock wire
  input wire logic sda, // Resolved data wire
  input wire logic d_sda_oe_n, // Device data pull, low drives
  input wire logic cfg_rd, // Config read pulse
  input wire logic [4:0] cfg_port, // Port to read
  input wire logic [11:0] cfg_addr, // Byte address
  input wire logic [3:0] cfg_be // Byte enables
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  logic sda_q_r;
  logic [9:0] low_cnt_r;
  logic [1:0] rd_cnt_r;
  ////////////////////////////////////////////////////////////////////////////
  // Cycles since SCL fell, reads per START
  always_ff @(posedge clk_sys) begin
    sda_q_r <= sda;
    if (rst || scl) begin
      low_cnt_r <= 10'h000;
    end else if (low_cnt_r != 10'h3FF) begin
      low_cnt_r <= low_cnt_r + 10'h001;
    end
    if (rst || (scl && sda_q_r && !sda)) begin
      rd_cnt_r <= 2'h0;
    end else if (cfg_rd && rd_cnt_r != 2'h3) begin
      rd_cnt_r <= rd_cnt_r + 2'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_start;
    scl && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $rose(sda);
  endsequence
  a_addr_low: assert property (cfg_rd |-> cfg_addr[1:0] == 2'h0)
    else $error("config address low bits not zero");
  a_port_range: assert property (cfg_rd |-> cfg_port <= PORT_LAST)
    else $error("config read to port above five");
  a_rd_pulse: assert property (cfg_rd |=> !cfg_rd)
    else $error("config read longer than one cycle");
  a_cfg_hold: assert property (!cfg_rd |-> $stable({cfg_port, cfg_addr, cfg_be}))
    else $error("stored setup changed without a read");
  a_sda_hold_high: assert property (scl && $past(scl) |-> $stable(d_sda_oe_n))
    else $error("device changed data while clock high");
  a_stop_release: assert property (s_stop |-> d_sda_oe_n)
    else $error("device driving data at stop");
  a_start_release: assert property (s_start |-> d_sda_oe_n)
    else $error("device driving data at start");
  a_drive_timing: assert property ($fell(d_sda_oe_n) |-> !scl && low_cnt_r <= 10'd159)
    else $error("device began driving late or with clock high");
  a_one_read: assert property (rd_cnt_r <= 2'h1)
    else $error("more than one config read in a transaction");
endmodule : smbcr_monitor

// ==== bench/smbcr_tb.sv ====
// Self-checking bench joining host and device ends over SMBus wires
`timescale 1ns/100ps
module smbcr_tb;
  import smbcr_pkg::*;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic cfg_rd;
  logic [4:0] cfg_port;
  logic [11:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_rdata = 32'h0000_0000;
  int fail_count = 0;
  int total_checks = 0;
  // Port 5, enables 0101b, address FFCh
  localparam logic [31:0] GOOD_SETUP = 32'h0402_97FF;
  localparam logic [31:0] EXP_DATA = {5'h05, 3'h5, 4'h5, 12'hFFC, 8'hC3};
  always #2 clk_sys = ~clk_sys;
  initial begin
    #31;
    forever #62.5 clk_link = ~clk_link;
  end
  ////////////////////////////////////////////////////////////////////////////
  smbcr_if bif ();
  smbcr_host #(.QCYC(64)) i_smbcr_host (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus(bif));
  smbcr_dev i_smbcr_dev (.clk_sys(clk_sys), .clk_link(clk_link), .rst(rst), .cfg_rd(cfg_rd),
    .cfg_port(cfg_port), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_rdata(cfg_rdata), .bus(bif));
  smbcr_monitor i_smbcr_monitor (.clk_sys(clk_sys), .rst(rst), .scl(bif.scl), .sda(bif.sda),
    .d_sda_oe_n(bif.d_sda_oe_n), .cfg_rd(cfg_rd), .cfg_port(cfg_port), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be));
  // Config space stand-in: valid in the cycle after the request, then alternates with its inverse
  always_ff @(posedge clk_sys) begin
    if (cfg_rd) begin
      cfg_rdata <= {cfg_port, 3'h5, cfg_be, cfg_addr, 8'hC3};
    end else begin
      cfg_rdata <= ~cfg_rdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read
  // Start one transaction and poll until done, bounded
  task automatic run(input logic [31:0] w, input logic [2:0] cmd, output logic [31:0] s);
    int n;
    n = 0;
    reg_write(REG_SETUP, w);
    reg_write(REG_CMD, {29'h0, cmd});
    do begin
      reg_read(REG_STAT, s);
      n++;
    end while (s[STAT_DONE] !== 1'b1 && n < 20000);
  endtask : run
  function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ PEC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction : crc_byte
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_good_read();
    logic [31:0] s;
    logic [7:0] c;
    logic [7:0] bytes [8];
    bytes = '{8'hD0, 8'hBD, 8'hD1, 8'h04, EXP_DATA[31:24], EXP_DATA[23:16], EXP_DATA[15:8], EXP_DATA[7:0]};
    c = 8'h00;
    foreach (bytes[i]) c = crc_byte(c, bytes[i]);
    run(GOOD_SETUP, 3'h0 | {1'b0, OP_SETUP}, s);
    check({29'h0, s[2:0]}, 32'h0000_0004);
    run(32'h0000_0000, {1'b1, OP_READ}, s);
    check({29'h0, s[2:0]}, 32'h0000_0004);
    reg_read(REG_RDATA, s);
    check(s, EXP_DATA);
    reg_read(REG_RINFO, s);
    check({16'h0, s[15:0]}, {16'h0, c, RET_CNT});
    check({27'h0, cfg_port}, 32'h0000_0005);
    check({20'h0, cfg_addr}, 32'h0000_0FFC);
    check({28'h0, cfg_be}, 32'h0000_0005);
    reg_read(REG_CMD, s);
    check(s, {29'h0, 1'b1, OP_READ});
    reg_read(REG_ADDR, s);
    check(s, {25'h0, SLV_ADDR});
  endtask : t_good_read
  task automatic t_refused_keeps_setup();
    logic [31:0] s;
    // Port select 6 is refused
    run(32'h0403_3C00, {1'b0, OP_SETUP}, s);
    check({29'h0, s[2:0]}, 32'h0000_0006);
    run(32'h0000_0000, {1'b0, OP_READ}, s);
    check({29'h0, s[2:0]}, 32'h0000_0004);
    reg_read(REG_RDATA, s);
    check(s, EXP_DATA);
    reg_read(REG_RINFO, s);
    check({24'h0, s[7:0]}, {24'h0, RET_CNT});
    check({27'h0, cfg_port}, 32'h0000_0005);
  endtask : t_refused_keeps_setup
  task automatic results();
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////
  // Reset spans several link periods so the link side sees it
  initial begin
    repeat (120) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (140) @(posedge clk_sys);
    t_good_read();
    t_refused_keeps_setup();
    results();
  end
  initial begin
    // Four transactions need about 72k cycles at this quarter length
    repeat (90000) @(posedge clk_sys);
    fail_count++;
    results();
  end
endmodule : smbcr_tb
